// File: shared/scanner_image_if.sv
// Purpose: Register image shared by host controller and scanner
// Assumes: Both ends run on the same clock
// Notes:   Command side driven by host, status side by scanner

`timescale 1ns/1ps

interface scanner_image_if;
    import scanner_pkg::*;
    logic [7:0]  command_bits;
    logic [15:0] tx_buffer_start;
    logic [15:0] tx_buffer_length;
    logic [15:0] rx_buffer_start;
    logic [15:0] rx_buffer_size;
    logic [15:0] status_bits;
    logic [15:0] online_words [ONLINE_WORDS];
    logic [15:0] fault_node_and_code;
    logic [15:0] fault_detail_data;

    modport scanner (
        input  command_bits, tx_buffer_start, tx_buffer_length,
        input  rx_buffer_start, rx_buffer_size,
        output status_bits, online_words, fault_node_and_code, fault_detail_data
    );
    modport host (
        output command_bits, tx_buffer_start, tx_buffer_length,
        output rx_buffer_start, rx_buffer_size,
        input  status_bits, online_words, fault_node_and_code, fault_detail_data
    );
endinterface : scanner_image_if

// File: shared/scanner_pkg.sv
// Purpose: Shared constants and types of the scanner register image
// Assumes: One system clock, synchronous active-high reset
// Notes:   Status and command bit positions count from bit 0

package scanner_pkg;

    // ------------------------------------------------------------
    // Image sizes
    // ------------------------------------------------------------
    localparam int NODE_COUNT   = 64;
    localparam int NODE_AW      = 6;
    localparam int CODE_W       = 8;
    localparam int DATA_W       = 16;
    localparam int CMD_BITS     = 8;
    localparam int CMD_WORDS    = 4;
    localparam int STATUS_BITS  = 16;
    localparam int STATUS_WORDS = 6;
    localparam int ONLINE_WORDS = 4;

    // ------------------------------------------------------------
    // Command and status bit positions
    // ------------------------------------------------------------
    localparam int CMD_STOP_SCAN   = 0;
    localparam int CMD_SEND_EXPL   = 1;
    localparam int CMD_SHOW_FIRST  = 2;
    localparam int CMD_SHOW_NEXT   = 3;
    localparam int CMD_CLEAR_FLT   = 4;
    localparam int CMD_USED_BITS   = 5;
    localparam int ST_OFFLINE      = 0;
    localparam int ST_STOPPED      = 1;
    localparam int ST_EXPL_DONE    = 2;
    localparam int ST_ERR_LSB      = 3;
    localparam int ST_ERR_W        = 9;

    // ------------------------------------------------------------
    // Fault codes
    // ------------------------------------------------------------
    localparam logic [7:0] FC_NONE      = 8'h00;
    localparam logic [7:0] FC_SCAN_TIME = 8'h01;
    localparam logic [7:0] FC_CONS_SIZE = 8'h0d;
    localparam logic [7:0] FC_PROD_SIZE = 8'h0e;

    // ------------------------------------------------------------
    // Software register offsets (APB byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_COMMAND  = 8'h00;
    localparam logic [7:0] OFS_TX_START = 8'h04;
    localparam logic [7:0] OFS_TX_LEN   = 8'h08;
    localparam logic [7:0] OFS_RX_START = 8'h0c;
    localparam logic [7:0] OFS_RX_SIZE  = 8'h10;
    localparam logic [7:0] OFS_STATUS   = 8'h14;
    localparam logic [7:0] OFS_ONLINE0  = 8'h18;
    localparam logic [7:0] OFS_FAULT_NC = 8'h28;
    localparam logic [7:0] OFS_FAULT_DD = 8'h2c;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_CMD  = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [5:0]  RST_SEL  = 6'h00;

    typedef enum logic [0:0] {
        APB_WAIT = 1'b0,
        APB_DONE = 1'b1
    } apb_state_t;

endpackage : scanner_pkg

// File: src/fault_seek.sv
// Purpose: Find the first faulted node at or after a start index
// Assumes: Mask bit set means the node holds a fault entry
// Notes:   Search wraps past the top node back to node 0

`timescale 1ns/1ps

module fault_seek
    import scanner_pkg::*;
#(
    parameter int NODES = NODE_COUNT,
    parameter int AW    = NODE_AW
) (
    input  wire logic [NODES-1:0] mask_in,
    input  wire logic [AW-1:0]    from_in,
    output logic                  found_out,
    output logic [AW-1:0]         index_out
);
    logic [AW-1:0] probe;

    always_comb begin
        found_out = 1'b0;
        index_out = from_in;
        probe     = from_in;
        // Walk downwards so the nearest hit is the one left standing
        for (int i = NODES - 1; i >= 0; i--) begin
            probe = from_in + AW'(i);
            if (mask_in[probe]) begin
                found_out = 1'b1;
                index_out = probe;
            end
        end
    end

endmodule : fault_seek

// File: src/scanner_fault_table.sv
// Purpose: Scanner end: fault table, status image and online bitmaps
// Assumes: Report and online inputs come from logic on CLOCK_IN
// Notes:   Fault table holds one code and one detail word per node
//
// Functional notes
// [RULE1] One entry per node, one shown
// [RULE2] Show-first selects lowest faulted node
// [RULE3] Show-next advances, wraps to first
// [RULE4] Clear-faults erases every table entry; a report accepted in the clearing cycle is kept
// [RULE5] Host never sets two fault commands
// [RULE6] Display word one low byte: node
// [RULE7] Display word one high byte: code
// [RULE8] Only higher code replaces stored code; here a code-one report also replaces a stored code one
// [RULE9] Code one shows scan interval otherwise
// [RULE10] Scan time fills second word, milliseconds
// [RULE11] Consumption error: reported high, configured low
// [RULE12] Production error: reported high, configured low
// [RULE13] Other codes: second word meaningless
// [RULE14] Overlapped polls, many responses pending
// [RULE15] Host settles, clears, waits, then reads
// [RULE16] Eight bits, four words, sixteen bits, six
// [RULE17] Command bit assignment, six-eight reserved
// [RULE18] Four descriptor words in fixed order
// [RULE19] Status bit assignment, thirteen-sixteen reserved
// [RULE20] Four online words, sixteen nodes each
// [RULE21] Node zero in bit zero
// [RULE22] Online only while polled exchange runs
// [RULE23] Stop scanning releases links, flags stopped
// [RULE24] Fault commands act on rising edge
//
// Chosen here: the APB slave port and the placing of the registers.

`timescale 1ns/1ps

module scanner_fault_table
    import scanner_pkg::*;
#(
    parameter int NODES = NODE_COUNT
) (
    input  wire logic            CLOCK_IN,
    input  wire logic            SRST_IN,
    scanner_image_if.scanner     IMAGE,
    input  wire logic            REPORT_VALID_IN,
    input  wire logic [5:0]      REPORT_NODE_IN,
    input  wire logic [7:0]      REPORT_CODE_IN,
    input  wire logic [15:0]     REPORT_DATA_IN,
    input  wire logic [63:0]     NODE_ONLINE_IN,
    input  wire logic [63:0]     NODE_CONFIGURED_IN,
    input  wire logic            EXPLICIT_DONE_IN,
    input  wire logic [8:0]      EXPLICIT_ERROR_IN,
    output logic                 SCAN_HALT_OUT,
    output logic                 EXPLICIT_REQUEST_OUT,
    output logic [15:0]          TX_START_OUT,
    output logic [15:0]          TX_LENGTH_OUT,
    output logic [15:0]          RX_START_OUT,
    output logic [15:0]          RX_SIZE_OUT
);
    // ------------------------------------------------------------
    // Table storage and selection
    // ------------------------------------------------------------
    logic [7:0]        code_r [NODES];
    logic [15:0]       data_r [NODES];
    logic [NODES-1:0]  faulted;
    logic [7:0]        cmd_prev_r;
    logic [5:0]        sel_r;
    logic [5:0]        sel_nxt;
    logic [5:0]        seek_from;
    logic [5:0]        seek_index;
    logic              seek_found;
    logic              first_edge;
    logic              next_edge;
    logic              clear_edge;
    logic              stopped;
    logic [7:0]        base_code;
    logic              accept;
    logic [15:0]       status_r;
    logic [15:0]       online_r [ONLINE_WORDS];
    logic [15:0]       node_code_r;
    logic [15:0]       detail_r;

    // ------------------------------------------------------------
    // Command edges
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            cmd_prev_r <= RST_CMD;
        end else begin
            cmd_prev_r <= IMAGE.command_bits;
        end
    end

    // Levels would re-run the search every cycle and spin the display
    assign first_edge = IMAGE.command_bits[CMD_SHOW_FIRST]
                        & ~cmd_prev_r[CMD_SHOW_FIRST];   // [RULE24] [RULE17]
    assign next_edge  = IMAGE.command_bits[CMD_SHOW_NEXT]
                        & ~cmd_prev_r[CMD_SHOW_NEXT];    // [RULE24]
    assign clear_edge = IMAGE.command_bits[CMD_CLEAR_FLT]
                        & ~cmd_prev_r[CMD_CLEAR_FLT];    // [RULE24]
    assign stopped    = IMAGE.command_bits[CMD_STOP_SCAN];

    // ------------------------------------------------------------
    // Fault table update
    // ------------------------------------------------------------
    // A report in the clearing cycle survives: it is judged against zero
    assign base_code = clear_edge ? FC_NONE : code_r[REPORT_NODE_IN];
    // Scan time keeps refreshing while nothing worse is stored
    assign accept = REPORT_VALID_IN
                    & ((REPORT_CODE_IN > base_code)                 // [RULE8]
                       | ((REPORT_CODE_IN == FC_SCAN_TIME)
                          & (base_code <= FC_SCAN_TIME)));          // [RULE9]

    // Reports from different nodes may arrive in any interleaving
    always_ff @(posedge CLOCK_IN) begin
        for (int i = 0; i < NODES; i++) begin
            if (SRST_IN) begin
                code_r[i] <= FC_NONE;
                data_r[i] <= RST_WORD;
            end else if (accept && (REPORT_NODE_IN == 6'(i))) begin // [RULE14]
                code_r[i] <= REPORT_CODE_IN;
                // Sizes arrive packed reported-high, configured-low
                data_r[i] <= REPORT_DATA_IN;               // [RULE10] [RULE11] [RULE12]
            end else if (clear_edge) begin
                code_r[i] <= FC_NONE;                      // [RULE4]
                data_r[i] <= RST_WORD;
            end
        end
    end

    // ------------------------------------------------------------
    // Selection of the shown node
    // ------------------------------------------------------------
    generate
        for (genvar g = 0; g < NODES; g++) begin : g_mask
            assign faulted[g] = (code_r[g] != FC_NONE);
        end
    endgenerate

    assign seek_from = first_edge ? RST_SEL : 6'(sel_r + 6'h01);

    fault_seek #(
        .NODES (NODES),
        .AW    (NODE_AW)
    ) u_seek (
        .mask_in   (faulted),
        .from_in   (seek_from),
        .found_out (seek_found),
        .index_out (seek_index)
    );

    always_comb begin
        sel_nxt = sel_r;
        if (first_edge) begin
            sel_nxt = seek_found ? seek_index : RST_SEL;   // [RULE2]
        end else if (next_edge && seek_found) begin
            sel_nxt = seek_index;                          // [RULE3]
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            sel_r <= RST_SEL;
        end else begin
            sel_r <= sel_nxt;
        end
    end

    // ------------------------------------------------------------
    // Display words
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            node_code_r <= RST_WORD;
            detail_r    <= RST_WORD;
        end else begin
            node_code_r <= {code_r[sel_r], 2'h0, sel_r};   // [RULE1] [RULE6] [RULE7]
            // Detail shown as stored; meaningless for other codes
            detail_r    <= data_r[sel_r];                  // [RULE13]
        end
    end

    // ------------------------------------------------------------
    // Status bits and online bitmaps
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            status_r <= RST_WORD;
        end else begin
            status_r                 <= RST_WORD;          // [RULE19]
            status_r[ST_OFFLINE]     <= |(NODE_CONFIGURED_IN
                                          & ~(NODE_ONLINE_IN & {64{~stopped}}));
            status_r[ST_STOPPED]     <= stopped;           // [RULE23]
            status_r[ST_EXPL_DONE]   <= EXPLICIT_DONE_IN;
            status_r[ST_ERR_LSB +: ST_ERR_W] <= EXPLICIT_ERROR_IN;
        end
    end

    generate
        for (genvar w = 0; w < ONLINE_WORDS; w++) begin : g_online
            always_ff @(posedge CLOCK_IN) begin
                if (SRST_IN) begin
                    online_r[w] <= RST_WORD;
                end else begin
                    // A stopped scanner holds no connections
                    online_r[w] <= NODE_ONLINE_IN[w*16 +: 16]
                                   & {16{~stopped}};       // [RULE20] [RULE21] [RULE22]
                end
            end
            assign IMAGE.online_words[w] = online_r[w];
        end
    endgenerate

    assign IMAGE.status_bits         = status_r;           // [RULE16]
    assign IMAGE.fault_node_and_code = node_code_r;
    assign IMAGE.fault_detail_data   = detail_r;

    // ------------------------------------------------------------
    // Toward the message engine
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            SCAN_HALT_OUT        <= 1'b0;
            EXPLICIT_REQUEST_OUT <= 1'b0;
            TX_START_OUT         <= RST_WORD;
            TX_LENGTH_OUT        <= RST_WORD;
            RX_START_OUT         <= RST_WORD;
            RX_SIZE_OUT          <= RST_WORD;
        end else begin
            SCAN_HALT_OUT        <= stopped;               // [RULE23]
            EXPLICIT_REQUEST_OUT <= IMAGE.command_bits[CMD_SEND_EXPL] & ~stopped;
            TX_START_OUT         <= IMAGE.tx_buffer_start; // [RULE18]
            TX_LENGTH_OUT        <= IMAGE.tx_buffer_length;
            RX_START_OUT         <= IMAGE.rx_buffer_start;
            RX_SIZE_OUT          <= IMAGE.rx_buffer_size;
        end
    end

endmodule : scanner_fault_table

// File: src/scanner_host_ctrl.sv
// Purpose: Host end: APB registers driving the scanner register image
// Assumes: APB master and scanner share CLOCK_IN
// Notes:   One wait state on every access

`timescale 1ns/1ps

module scanner_host_ctrl
    import scanner_pkg::*;
(
    input  wire logic         CLOCK_IN,
    input  wire logic         SRST_IN,
    scanner_image_if.host     IMAGE,
    input  wire logic         PSEL_IN,
    input  wire logic         PENABLE_IN,
    input  wire logic         PWRITE_IN,
    input  wire logic [7:0]   PADDR_IN,
    input  wire logic [31:0]  PWDATA_IN,
    output logic [31:0]       PRDATA_OUT,
    output logic              PREADY_OUT,
    output logic              PSLVERR_OUT
);
    // ------------------------------------------------------------
    // Command image
    // ------------------------------------------------------------
    logic [7:0]  command_r;
    logic [15:0] desc_r [CMD_WORDS];
    apb_state_t  state_r;
    logic        access;
    logic        known;
    logic        bad_cmd;
    logic [31:0] rdata;
    logic [4:0]  word_idx;

    assign access   = PSEL_IN & PENABLE_IN;
    assign word_idx = PADDR_IN[6:2];
    // Two fault commands at once would leave the scanner undefined
    assign bad_cmd  = PWRITE_IN && (PADDR_IN == OFS_COMMAND)
                      && ($countones(PWDATA_IN[CMD_CLEAR_FLT:CMD_SHOW_FIRST]) > 1); // [RULE5]

    always_comb begin
        known = (PADDR_IN[1:0] == 2'h0) && (PADDR_IN <= OFS_FAULT_DD);
        rdata = 32'h0000_0000;
        if (PADDR_IN == OFS_COMMAND) begin
            rdata[7:0] = command_r;
        end else if (PADDR_IN <= OFS_RX_SIZE) begin
            rdata[15:0] = desc_r[2'(word_idx - 5'h01)];
        end else if (PADDR_IN == OFS_STATUS) begin
            rdata[15:0] = IMAGE.status_bits;
        end else if (PADDR_IN < OFS_FAULT_NC) begin
            rdata[15:0] = IMAGE.online_words[2'(word_idx - OFS_ONLINE0[6:2])];
        end else if (PADDR_IN == OFS_FAULT_NC) begin
            rdata[15:0] = IMAGE.fault_node_and_code;
        end else begin
            rdata[15:0] = IMAGE.fault_detail_data;
        end
        if (!known) begin
            rdata = 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            state_r     <= APB_WAIT;
            PREADY_OUT  <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT  <= 32'h0000_0000;
        end else if (access && state_r == APB_WAIT) begin
            state_r     <= APB_DONE;
            PREADY_OUT  <= 1'b1;
            PSLVERR_OUT <= ~known | bad_cmd;
            PRDATA_OUT  <= PWRITE_IN ? 32'h0000_0000 : rdata;
        end else begin
            state_r     <= APB_WAIT;
            PREADY_OUT  <= 1'b0;
            PSLVERR_OUT <= 1'b0;
        end
    end

    // Write lands on the edge that completes the access
    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            command_r <= RST_CMD;
            for (int i = 0; i < CMD_WORDS; i++) begin
                desc_r[i] <= RST_WORD;
            end
        end else if (access && PWRITE_IN && state_r == APB_DONE && known && !bad_cmd) begin
            if (PADDR_IN == OFS_COMMAND) begin
                // Reserved bits stay zero
                command_r <= {3'h0, PWDATA_IN[CMD_USED_BITS-1:0]};   // [RULE17]
            end else if (PADDR_IN <= OFS_RX_SIZE) begin
                desc_r[2'(word_idx - 5'h01)] <= PWDATA_IN[15:0];     // [RULE18]
            end
        end
    end

    assign IMAGE.command_bits     = command_r;    // [RULE16]
    assign IMAGE.tx_buffer_start  = desc_r[0];
    assign IMAGE.tx_buffer_length = desc_r[1];
    assign IMAGE.rx_buffer_start  = desc_r[2];
    assign IMAGE.rx_buffer_size   = desc_r[3];

endmodule : scanner_host_ctrl

// File: verif/fieldbus_scanner_fault_table_asserts.sv
// Purpose: Interface-level checks of the scanner register image
// Assumes: Both ends on CLOCK_IN, synchronous active-high reset
// Notes:   Bench keeps reports idle for two edges after a clear command
`timescale 1ns/1ps
module fieldbus_scanner_fault_table_asserts
    import scanner_pkg::*;
(
    input wire logic        CLOCK_IN,
    input wire logic        SRST_IN,
    input wire logic [7:0]  command_bits,
    input wire logic [15:0] status_bits,
    input wire logic [15:0] online_words [ONLINE_WORDS],
    input wire logic [15:0] fault_node_and_code
);
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (SRST_IN);
    // ------------------------------------------------------------
    // Image checks
    // ------------------------------------------------------------
    property p_cmd_reserved;
        command_bits[7:5] == 3'h0;
    endproperty
    a_cmd_reserved: assert property (p_cmd_reserved)
        else $error("reserved command bits set");
    property p_one_fault_cmd;
        $onehot0(command_bits[4:2]);
    endproperty
    a_one_fault_cmd: assert property (p_one_fault_cmd)
        else $error("two fault commands at once");
    property p_status_reserved;
        status_bits[15:12] == 4'h0;
    endproperty
    a_status_reserved: assert property (p_status_reserved)
        else $error("reserved status bits set");
    property p_stop_flag;
        $stable(command_bits[CMD_STOP_SCAN]) |-> status_bits[ST_STOPPED] == command_bits[0];
    endproperty
    a_stop_flag: assert property (p_stop_flag)
        else $error("stopped flag does not follow stop command");
    property p_stop_online;
        command_bits[0] && $past(command_bits[0]) |->
            (online_words[0] | online_words[1] | online_words[2] | online_words[3]) == 16'h0;
    endproperty
    a_stop_online: assert property (p_stop_online)
        else $error("node online while scanning stopped");
    property p_node_byte;
        fault_node_and_code[7:6] == 2'b00;
    endproperty
    a_node_byte: assert property (p_node_byte)
        else $error("node byte above top address");
    property p_code_range;
        fault_node_and_code[15:8] <= 8'h0e;
    endproperty
    a_code_range: assert property (p_code_range)
        else $error("fault code out of range");
    property p_clear_zero;
        $rose(command_bits[CMD_CLEAR_FLT]) |-> ##2 fault_node_and_code[15:8] == 8'h00;
    endproperty
    a_clear_zero: assert property (p_clear_zero)
        else $error("fault code shown after clear");
endmodule : fieldbus_scanner_fault_table_asserts

// File: verif/fieldbus_scanner_fault_table_test.sv
// Purpose: Self-checking bench for host controller and scanner end
// Assumes: APB answer waits on PREADY; reports idle around commands
// Notes:   Fault table model kept in bench arrays
`timescale 1ns/1ps
module fieldbus_scanner_fault_table_test;
    import scanner_pkg::*;
    logic        clk, srst, psel, penable, pwrite, pready, pslverr, rv, xdone, halt, er, xreq;
    logic [7:0]  paddr, rcode;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0]  rnode;
    logic [15:0] rdata, txs, txl, rxs, rxz;
    logic [63:0] online, cfg;
    logic [8:0]  xerr;
    logic [15:0] v     [4];
    logic [7:0]  mcode [NODE_COUNT];
    logic [15:0] mdata [NODE_COUNT];
    int          err_count, cmp_count, sel;
    scanner_image_if img ();
    scanner_host_ctrl u_scanner_host_ctrl (.CLOCK_IN(clk), .SRST_IN(srst), .IMAGE(img),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr));
    scanner_fault_table u_scanner_fault_table (.CLOCK_IN(clk), .SRST_IN(srst), .IMAGE(img),
        .REPORT_VALID_IN(rv), .REPORT_NODE_IN(rnode), .REPORT_CODE_IN(rcode),
        .REPORT_DATA_IN(rdata), .NODE_ONLINE_IN(online), .NODE_CONFIGURED_IN(cfg),
        .EXPLICIT_DONE_IN(xdone), .EXPLICIT_ERROR_IN(xerr), .SCAN_HALT_OUT(halt),
        .EXPLICIT_REQUEST_OUT(xreq), .TX_START_OUT(txs), .TX_LENGTH_OUT(txl),
        .RX_START_OUT(rxs), .RX_SIZE_OUT(rxz));
    fieldbus_scanner_fault_table_asserts u_fieldbus_scanner_fault_table_asserts (
        .CLOCK_IN(clk), .SRST_IN(srst), .command_bits(img.command_bits),
        .status_bits(img.status_bits), .online_words(img.online_words),
        .fault_node_and_code(img.fault_node_and_code));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rdchk
    task automatic cmd(input logic [7:0] c);
        apb(1'b1, OFS_COMMAND, {24'h0, c});
        apb(1'b1, OFS_COMMAND, 32'h0);
    endtask : cmd
    // Model keeps the higher code; scan time refreshes itself
    task automatic report(input logic [5:0] n, input logic [7:0] c, input logic [15:0] d);
        @(posedge clk);
        rv <= 1'b1;
        rnode <= n;
        rcode <= c;
        rdata <= d;
        @(posedge clk);
        rv <= 1'b0;
        if (c > mcode[n] || (c == FC_SCAN_TIME && mcode[n] <= FC_SCAN_TIME)) begin
            mcode[n] = c;
            mdata[n] = d;
        end
    endtask : report
    task automatic show(input string nm);
        rdchk(nm, OFS_FAULT_NC, {16'h0, mcode[sel], 2'b00, sel[5:0]});
        if (mcode[sel] == FC_SCAN_TIME || mcode[sel] >= FC_CONS_SIZE)
            rdchk(nm, OFS_FAULT_DD, {16'h0, mdata[sel]});
    endtask : show
    function automatic int seek(input int from);
        for (int i = 0; i < NODE_COUNT; i++)
            if (mcode[(from + i) % NODE_COUNT] != 8'h00) return (from + i) % NODE_COUNT;
        return -1;
    endfunction : seek
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    // ------------------------------------------------------------
    // Clock, watchdog, tests
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end
    initial begin
        int s;
        logic [63:0] ov, cv;
        logic [8:0]  ev;
        srst = 1'b1;
        {psel, penable, pwrite, rv, xdone, paddr, pwdata, rcode, rnode, rdata} = '0;
        {online, cfg, xerr, err_count, cmp_count, sel} = '0;
        foreach (mcode[i]) {mcode[i], mdata[i]} = 24'h0;
        void'($urandom(2));
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        for (int a = 0; a < 12; a++) rdchk("reset value", 8'(a * 4), 32'h0);
        apb(1'b0, 8'h30, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, er});
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            v[i] = 16'($urandom);
            apb(1'b1, 8'(4 + 4 * i), {16'hffff, v[i]});
            rdchk("descriptor", 8'(4 + 4 * i), {16'h0, v[i]});
        end
        chk("descriptor out", {v[0], v[1], v[2], v[3]}, {txs, txl, rxs, rxz});
        apb(1'b1, OFS_COMMAND, 32'hff);
        chk("double command error", 32'h1, {31'h0, er});
        apb(1'b1, OFS_COMMAND, 32'he0);
        rdchk("reserved command", OFS_COMMAND, 32'h0);
        ov = {$urandom, $urandom};
        cv = ov | {$urandom, $urandom};
        ev = 9'($urandom);
        online <= ov;
        cfg <= cv;
        xerr <= ev;
        xdone <= 1'b1;
        apb(1'b1, OFS_COMMAND, 32'h2);
        for (int i = 0; i < 4; i++)
            rdchk("online", 8'(OFS_ONLINE0 + 4 * i), {16'h0, ov[16 * i +: 16]});
        rdchk("status", OFS_STATUS, {20'h0, ev, 2'b10, |(cv & ~ov)});
        chk("explicit request", 32'h1, {31'h0, xreq});
        apb(1'b1, OFS_COMMAND, 32'h3);
        rdchk("stopped status", OFS_STATUS, {20'h0, ev, 2'b11, |cv});
        rdchk("stopped online", OFS_ONLINE0, 32'h0);
        chk("halt and request", 32'h2, {30'h0, halt, xreq});
        apb(1'b1, OFS_COMMAND, 32'h0);
        $display("test status done");
        report(6'd9, 8'd5, 16'h1111);
        report(6'd9, 8'd2, 16'h2222);
        report(6'd9, FC_PROD_SIZE, 16'h3344);
        report(6'd3, FC_SCAN_TIME, 16'h0123);
        report(6'd3, FC_SCAN_TIME, 16'h0456);
        report(6'd63, FC_CONS_SIZE, 16'h0a08);
        for (int i = 0; i < 30; i++) report(6'($urandom), 8'($urandom_range(14, 0)), 16'($urandom));
        cmd(8'h04);
        s = seek(0);
        sel = (s < 0) ? 0 : s;
        show("first fault");
        for (int i = 0; i < 40; i++) begin
            cmd(8'h08);
            s = seek(sel + 1);
            if (s >= 0) sel = s;
            show("next fault");
        end
        // Level held across two writes must advance once only
        apb(1'b1, OFS_COMMAND, 32'h8);
        apb(1'b1, OFS_COMMAND, 32'h8);
        s = seek(sel + 1);
        sel = s;
        show("held next");
        apb(1'b1, OFS_COMMAND, 32'h0);
        cmd(8'h10);
        foreach (mcode[i]) {mcode[i], mdata[i]} = 24'h0;
        show("cleared");
        cmd(8'h04);
        sel = 0;
        show("empty first");
        report(6'd20, 8'd2, 16'h5555);
        cmd(8'h04);
        sel = 20;
        show("after clear");
        $display("test fault table done");
        tally_and_finish();
    end
endmodule : fieldbus_scanner_fault_table_test
